// ---- bench/chan_pin_model.sv ----
`timescale 1ns/10ps

// ----------------------------------
// far side: external channel pins
// ----------------------------------
module chan_pin_model
(
   input wire logic clk,
   input wire logic level_a,
   input wire logic level_b,
   input wire logic slow,
   input wire logic out_a,
   input wire logic oe_a,
   input wire logic out_b,
   input wire logic oe_b,
   output logic pin_a,
   output logic pin_b
);
   logic [2:0] dly_a = 3'h0;
   logic [2:0] dly_b = 3'h0;
   logic [1:0] held = 2'h0;

   // slow mode lags each change by three cycles, like a sluggish source
   always @(posedge clk)
   begin
      dly_a <= {dly_a[1:0], level_a};
      dly_b <= {dly_b[1:0], level_b};
      held <= slow ? {dly_b[2], dly_a[2]} : {level_b, level_a};
   end

   // a pin the device drives shows the device's level, not ours
   assign pin_a = oe_a ? out_a : held[0];
   assign pin_b = oe_b ? out_b : held[1];
endmodule

// ---- bench/timer_channel_enable_polarity_counter_tb.sv ----
`timescale 1ns/10ps
`include "tmr_chan_map.svh"

module timer_channel_enable_polarity_counter_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] be = 4'h0;
   logic [31:0] rdat;
   logic wreq;
   logic pin_a, pin_b, out_a, out_b, oe_a, oe_b, irq;
   logic lvl_a = 1'b0;
   logic lvl_b = 1'b0;
   logic slow = 1'b0;
   logic prep_a = 1'b0;
   logic prep_b = 1'b0;
   logic trig = 1'b0;
   logic [31:0] v, c0;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int src = 0;

   always #2 clk = ~clk;

   tmr_chan_top dut (.CORE_CLK(clk), .SRST(srst), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
      .CHAN_A_IN(pin_a), .CHAN_A_OUT(out_a), .CHAN_A_OE(oe_a),
      .CHAN_B_IN(pin_b), .CHAN_B_OUT(out_b), .CHAN_B_OE(oe_b),
      .OUT_PREP_A(prep_a), .OUT_PREP_B(prep_b), .TRIG_IN(trig), .IRQ(irq));

   chan_pin_model pins (.clk(clk), .level_a(lvl_a), .level_b(lvl_b),
      .slow(slow), .out_a(out_a), .oe_a(oe_a), .out_b(out_b), .oe_b(oe_b),
      .pin_a(pin_a), .pin_b(pin_b));

   // ----------------------------------
   // reporting
   // ----------------------------------
   task results;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
         $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      if (got !== exp)
         errors++;
   endtask

   task check_rng(input logic [31:0] got, input logic [31:0] lo,
      input logic [31:0] hi);
      samples_checked++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         errors++;
         $display("[ERR] %0t %h outside %h..%h", $time, got, lo, hi);
      end
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      // generous ceiling: the whole sequence needs about 1700 cycles
      if (cycles == 30000)
      begin
         errors++;
         $display("[ERR] %0t run timed out", $time);
         results();
      end
   end

   // ----------------------------------
   // bus master
   // ----------------------------------
   task bus_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] b);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      be <= b;
      wr <= 1'b1;
      do @(posedge clk); while (wreq !== 1'b0);
      wr <= 1'b0;
   endtask

   task bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      do @(posedge clk); while (wreq !== 1'b0);
      d = rdat;
      rd <= 1'b0;
   endtask

   function automatic logic exp_out(logic en, logic pol, logic prep);
      return en ? prep ^ pol : pol;
   endfunction

   task wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // drive the source selected by src, then look for the capture flag
   task edge_cap(input int bit_i, input logic lvl, input logic exp);
      bus_rd(`OFF_COUNT, c0);
      @(posedge clk);
      slow <= $urandom % 2;
      if (src == 0)
         lvl_a <= lvl;
      else if (src == 1)
         lvl_b <= lvl;
      else
         trig <= lvl;
      wait_cyc(14);
      bus_rd(`OFF_IRQ_STAT, v);
      check({31'h0, v[bit_i]}, {31'h0, exp});
      check({31'h0, irq}, {31'h0, exp & (bit_i == 0)});
      if (exp && bit_i == 0)
      begin
         bus_rd(`OFF_CAPT_A, v);
         check_rng(v, c0, c0 + 32'h0000_0030);
      end
      bus_wr(`OFF_IRQ_CLR, 32'h0000_0007, `BE_WORD);
   endtask

   // ----------------------------------
   // main sequence
   // ----------------------------------
   initial
   begin
      void'($urandom(28));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      bus_rd(`OFF_CHEP, v);
      check(v, 32'h0000_0000);
      bus_rd(`OFF_COUNT, v);
      check(v, 32'h0000_0000);
      bus_rd(8'h3C, v);
      check(v, 32'h0000_0000);
      // comp polarity left at 0 in output mode
      repeat (6)
      begin
         c0 = $urandom & 32'h0000_0033;
         bus_wr(`OFF_CHEP, c0, `BE_WORD);
         bus_rd(`OFF_CHEP, v);
         check(v, c0);
      end
      for (int p = 0; p < 4; p++)
      begin
         bus_wr(`OFF_CHEP, 32'h0000_0000, `BE_WORD);
         bus_wr(`OFF_CTRL, p << 8, `BE_WORD);
         bus_wr(`OFF_CHEP, 32'h0000_0033, `BE_WORD);
         bus_rd(`OFF_CHEP, v);
         check(v, p[1] ? 32'h0000_0011 : 32'h0000_0033);
         bus_wr(`OFF_CTRL, 32'h0000_0000, `BE_WORD);
      end
      for (int i = 0; i < 16; i++)
      begin
         c0 = {30'h0, i[2], i[1]} << (i[3] ? 4 : 0);
         bus_wr(`OFF_CHEP, c0, `BE_WORD);
         @(posedge clk);
         prep_a <= i[0];
         prep_b <= i[0];
         wait_cyc(4);
         v = {30'h0, i[3] ? oe_b : oe_a, i[3] ? out_b : out_a};
         check(v, {30'h0, i[1], exp_out(i[1], i[2], i[0])});
      end
      bus_wr(`OFF_CHEP, 32'h0000_0000, `BE_WORD);
      bus_wr(`OFF_CTRL, 32'h0000_0001, `BE_WORD);
      bus_wr(`OFF_IRQ_EN, 32'h0000_0001, `BE_WORD);
      // comp polarity stays 0 in every input case
      for (int m = 1; m < 4; m++)
         for (int pol = 0; pol < 2; pol++)
         begin
            src = m - 1;
            bus_wr(`OFF_CHEP, 32'h0000_0000, `BE_WORD);
            bus_wr(`OFF_MODE, m, `BE_WORD);
            bus_wr(`OFF_CHEP, pol ? 32'h0000_0003 : 32'h0000_0001,
               `BE_WORD);
            wait_cyc(10);
            bus_wr(`OFF_IRQ_CLR, 32'h0000_0007, `BE_WORD);
            edge_cap(0, 1'b1, pol == 0);
            edge_cap(0, 1'b0, pol == 1);
         end
      src = 0;
      bus_wr(`OFF_CHEP, 32'h0000_0000, `BE_WORD);
      bus_wr(`OFF_MODE, 32'h0000_0101, `BE_WORD);
      edge_cap(0, 1'b1, 1'b0);
      edge_cap(0, 1'b0, 1'b0);
      src = 1;
      bus_wr(`OFF_CHEP, 32'h0000_0010, `BE_WORD);
      edge_cap(1, 1'b1, 1'b1);
      edge_cap(1, 1'b0, 1'b0);
      src = 2;
      for (int q = 2; q < 4; q++)
      begin
         bus_wr(`OFF_CHEP, 32'h0000_0000, `BE_WORD);
         bus_wr(`OFF_MODE, 32'h0000_0003 | (q << 2), `BE_WORD);
         bus_wr(`OFF_CHEP, 32'h0000_0001, `BE_WORD);
         // capture on every 4th, then every 8th, rising edge
         for (int k = 0; k < (2 << q); k++)
            edge_cap(0, ~k[0], k == (2 << q) - 2);
      end
      src = 0;
      bus_wr(`OFF_CHEP, 32'h0000_0000, `BE_WORD);
      bus_wr(`OFF_MODE, 32'h0000_0005, `BE_WORD);
      bus_wr(`OFF_CHEP, 32'h0000_0001, `BE_WORD);
      edge_cap(0, 1'b1, 1'b0);
      bus_wr(`OFF_CHEP, 32'h0000_0000, `BE_WORD);
      bus_wr(`OFF_CHEP, 32'h0000_0001, `BE_WORD);
      edge_cap(0, 1'b0, 1'b0);
      edge_cap(0, 1'b1, 1'b0);
      edge_cap(0, 1'b0, 1'b0);
      edge_cap(0, 1'b1, 1'b1);
      bus_wr(`OFF_IRQ_EN, 32'h0000_0000, `BE_WORD);
      edge_cap(0, 1'b0, 1'b0);
      bus_wr(`OFF_CTRL, 32'h0000_0000, `BE_WORD);
      repeat (4)
      begin
         c0 = $urandom & 32'h0000_FFFF;
         bus_wr(`OFF_COUNT, c0, `BE_WORD);
         bus_rd(`OFF_COUNT, v);
         check(v, c0);
      end
      bus_wr(`OFF_COUNT, 32'h0000_ABCD, `BE_HALF);
      bus_wr(`OFF_COUNT, 32'h1234_5678, 4'hC);
      bus_rd(`OFF_COUNT, v);
      check(v, 32'h0000_ABCD);
      bus_wr(`OFF_CTRL, 32'h0000_0001, `BE_WORD);
      bus_wr(`OFF_COUNT, 32'h0000_4000, `BE_WORD);
      bus_rd(`OFF_COUNT, v);
      check_rng(v, 32'h0000_4001, 32'h0000_4004);
      bus_wr(`OFF_IRQ_CLR, 32'h0000_0007, `BE_WORD);
      bus_wr(`OFF_COUNT, 32'h0000_FFF0, `BE_WORD);
      wait_cyc(30);
      bus_rd(`OFF_IRQ_STAT, v);
      check(v & 32'h0000_0004, 32'h0000_0004);
      bus_wr(`OFF_IRQ_CLR, 32'h0000_0007, `BE_WORD);
      bus_rd(`OFF_IRQ_STAT, v);
      check(v, 32'h0000_0000);
      // second reset in mid-run: registers and counter back to zero
      @(posedge clk);
      srst <= 1'b1;
      wait_cyc(4);
      srst <= 1'b0;
      bus_rd(`OFF_CHEP, v);
      check(v, 32'h0000_0000);
      bus_rd(`OFF_COUNT, v);
      check(v, 32'h0000_0000);
      results();
   end
endmodule

// ---- common/tmr_chan_map.svh ----
// Functional notes
// - output mode: polarity 0 means active high, 1 means active low
// - input mode: comp polarity and polarity pick the capture edge; the code uses polarity alone, comp polarity is ignored
// - both bits 0: rising edge active, input not inverted
// - comp 0, polarity 1: falling edge active, input inverted
// - polarity bits ignore writes while protection level is 11 or 10
// - output drives active state only while the channel enable is 1
// - input mode captures only while the channel enable is 1
// - enable, polarity, comp polarity at bits 0,1,3; second channel 4,5,7
// - second channel bits behave like the first channel bits
// - counter read returns the current count in bits 15 to 0
// - counter write replaces the running count
// - counter accepts half-word and word accesses
// - mode select 00 is output, other values are inputs with a source
// - capture prescaler is cleared whenever the channel enable is 0
`ifndef TMR_CHAN_MAP_SVH
`define TMR_CHAN_MAP_SVH
`define OFF_CTRL 8'h00
`define OFF_IRQ_EN 8'h0C
`define OFF_IRQ_STAT 8'h10
`define OFF_IRQ_CLR 8'h14
`define OFF_MODE 8'h18
`define OFF_CHEP 8'h20
`define OFF_COUNT 8'h24
`define OFF_CAPT_A 8'h34
`define OFF_CAPT_B 8'h38
`define CTRL_COUNT_EN 0
`define CTRL_PROTECTION_LEVEL_LO 8
`define CTRL_MASK 32'h0000_0301
`define CTRL_RESET 32'h0000_0000
`define PROTECTION_LEVEL_LOCK_BIT 1
`define CHEP_RESET 16'h0000
`define CHEP_WR_MASK 16'h00BB
`define CHEP_POL_MASK 16'h00AA
`define CHEP_A_EN 0
`define CHEP_A_POL 1
`define CHEP_A_NPOL 3
`define CHEP_B_EN 4
`define CHEP_B_POL 5
`define CHEP_B_NPOL 7
`define MODE_A_MS 0
`define MODE_A_PSC 2
`define MODE_B_MS 8
`define MODE_B_PSC 10
`define MODE_MASK 32'h0000_0F0F
`define MODE_A_FIELD 32'h0000_000F
`define MODE_B_FIELD 32'h0000_0F00
`define MODE_RESET 32'h0000_0000
`define MS_OUTPUT 2'h0
`define MS_OWN 2'h1
`define MS_OTHER 2'h2
`define PSC_DIV1 2'h0
`define PSC_DIV2 2'h1
`define PSC_DIV4 2'h2
`define PSC_LAST_1 3'h0
`define PSC_LAST_2 3'h1
`define PSC_LAST_4 3'h3
`define PSC_LAST_8 3'h7
`define PSC_STEP 3'h1
`define COUNT_RESET 16'h0000
`define COUNT_STEP 16'h0001
`define COUNT_TOP 16'hFFFF
`define STAT_CAP_A 0
`define STAT_CAP_B 1
`define STAT_OVF 2
`define STAT_RESET 3'h0
`define BE_WORD 4'hF
`define BE_HALF 4'h3
`define ZERO32 32'h0000_0000
`endif

// ---- common/tmr_chan_pkg.sv ----
package tmr_chan_pkg;
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] psc;
      logic enable;
      logic polarity;
      logic comp_polarity;
   } chan_cfg_type;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } bus_req_type;
endpackage

// ---- rtl/chan_path.sv ----
`timescale 1ns/10ps
`include "tmr_chan_map.svh"

module chan_path
(
   input logic clk,
   input logic srst,
   input logic pin_in,
   input logic alt_in,
   input logic trig_in,
   input logic out_prep,
   input tmr_chan_pkg::chan_cfg_type cfg,
   input logic [15:0] count,
   output logic filt,
   output logic cap_pulse,
   output logic [15:0] cap_value,
   output logic pin_out,
   output logic pin_oe
);
   logic sync_1, sync_2, sync_3;
   logic src_prev;
   logic [2:0] psc_cnt;
   wire logic input_mode;
   wire logic src_raw;
   wire logic src;
   wire logic active_edge;
   wire logic [2:0] psc_last;
   wire logic psc_hit;

   assign input_mode = cfg.mode != `MS_OUTPUT;
   assign src_raw = (cfg.mode == `MS_OWN) ? filt :
      (cfg.mode == `MS_OTHER) ? alt_in : trig_in;
   // comp polarity set is reserved; it is left out of the edge choice
   assign src = src_raw ^ cfg.polarity;
   assign active_edge = src & ~src_prev;
   assign psc_last = (cfg.psc == `PSC_DIV1) ? `PSC_LAST_1 :
      (cfg.psc == `PSC_DIV2) ? `PSC_LAST_2 :
      (cfg.psc == `PSC_DIV4) ? `PSC_LAST_4 : `PSC_LAST_8;
   assign psc_hit = psc_cnt == psc_last;
   assign cap_pulse = active_edge & cfg.enable & input_mode & psc_hit;

   always_ff @(posedge clk)
   begin
      sync_1 <= pin_in;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
      if (srst)
      begin
         filt <= 1'b0;
         src_prev <= 1'b0;
         psc_cnt <= `PSC_LAST_1;
         cap_value <= `COUNT_RESET;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end
      else
      begin
         if (sync_2 == sync_3)
            filt <= sync_3;
         src_prev <= src;
         if (!cfg.enable)
            psc_cnt <= `PSC_LAST_1;
         else if (active_edge && input_mode)
            psc_cnt <= psc_hit ? `PSC_LAST_1 : psc_cnt + `PSC_STEP;
         if (cap_pulse)
            cap_value <= count;
         // disabled or input: output rests at the inactive level
         pin_out <= (cfg.enable && !input_mode) ?
            out_prep ^ cfg.polarity : cfg.polarity;
         pin_oe <= cfg.enable & ~input_mode;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   a_cap_gated: assert property (!cfg.enable |-> !cap_pulse)
      else $error("capture while channel disabled");
   a_psc_clear: assert property (
      !cfg.enable |=> psc_cnt == `PSC_LAST_1)
      else $error("prescaler not cleared");
   a_rise_edge: assert property (
      (cfg.enable && input_mode && !cfg.polarity && $stable(cfg.polarity)
      && psc_hit && $rose(src_raw)) |-> cap_pulse)
      else $error("rising edge missed");
   a_fall_edge: assert property (
      (cfg.enable && input_mode && cfg.polarity && $stable(cfg.polarity)
      && psc_hit && $fell(src_raw)) |-> cap_pulse)
      else $error("falling edge missed");
   a_out_level: assert property (
      (cfg.enable && !input_mode) |=>
      pin_oe && pin_out == $past(out_prep ^ cfg.polarity))
      else $error("output level wrong");
endmodule

// ---- rtl/tmr_chan_top.sv ----
`timescale 1ns/10ps
`include "tmr_chan_map.svh"

module tmr_chan_top
(
   input logic CORE_CLK,
   input logic SRST,
   input logic [7:0] AVS_ADDRESS,
   input logic AVS_READ,
   input logic AVS_WRITE,
   input logic [31:0] AVS_WRITEDATA,
   input logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input logic CHAN_A_IN,
   output logic CHAN_A_OUT,
   output logic CHAN_A_OE,
   input logic CHAN_B_IN,
   output logic CHAN_B_OUT,
   output logic CHAN_B_OE,
   input logic OUT_PREP_A,
   input logic OUT_PREP_B,
   input logic TRIG_IN,
   output logic IRQ
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   tmr_chan_pkg::bus_req_type req;
   tmr_chan_pkg::chan_cfg_type cfg_a;
   tmr_chan_pkg::chan_cfg_type cfg_b;

   logic waitreq;
   logic [31:0] rdata;
   logic [31:0] ctrl;
   logic [31:0] mode_reg;
   logic [15:0] chep;
   logic [15:0] count;
   logic [2:0] irq_en;
   logic [2:0] stat;
   logic irq;

   wire logic req_any;
   wire logic wr_go;
   wire logic rd_take;
   wire logic sel_ctrl;
   wire logic sel_en;
   wire logic sel_stat;
   wire logic sel_clr;
   wire logic sel_mode;
   wire logic sel_chep;
   wire logic sel_count;
   wire logic sel_capt_a;
   wire logic sel_capt_b;
   wire logic [31:0] rd_mux;

   wire logic count_enable;
   wire logic [1:0] protection_level;
   wire logic locked;
   wire logic chan_a_enable;
   wire logic chan_a_polarity;
   wire logic chan_a_comp_polarity;
   wire logic chan_b_enable;
   wire logic chan_b_polarity;
   wire logic chan_b_comp_polarity;

   wire logic [31:0] ctrl_wr;
   wire logic [31:0] mode_wr;
   wire logic [31:0] mode_hold;
   wire logic [31:0] next_mode;
   wire logic [15:0] chep_wr;
   wire logic [15:0] pol_keep;
   wire logic [15:0] next_chep;
   wire logic [15:0] count_wr;
   wire logic wr_count;
   wire logic [15:0] next_count;
   wire logic overflow_evt;
   wire logic [2:0] events;
   wire logic [2:0] clr_bits;
   wire logic [2:0] next_stat;
   wire logic [2:0] next_irq_en;
   wire logic [31:0] en_wr;

   wire logic filtered_input_a_to_a;
   wire logic filtered_input_b_to_a;
   wire logic cap_a_pulse;
   wire logic cap_b_pulse;
   wire logic [15:0] cap_a_value;
   wire logic [15:0] cap_b_value;
   wire logic chan_a_output;
   wire logic chan_a_oe;
   wire logic chan_b_output;
   wire logic chan_b_oe;

   // ---------------------------------------------------------------
   // byte lane merge
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge_lanes
   (
      input logic [31:0] old,
      input logic [31:0] wdata,
      input logic [3:0] be
   );
      logic [31:0] mask;
      mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge_lanes = (wdata & mask) | (old & ~mask);
   endfunction

   // ---------------------------------------------------------------
   // bus slave decode
   // ---------------------------------------------------------------
   assign req = {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA,
      AVS_BYTEENABLE};
   assign req_any = req.read | req.write;
   // one wait cycle per access; the write lands on the release edge
   assign wr_go = req.write & ~waitreq;
   assign rd_take = req.read & waitreq;

   assign sel_ctrl = req.addr == `OFF_CTRL;
   assign sel_en = req.addr == `OFF_IRQ_EN;
   assign sel_stat = req.addr == `OFF_IRQ_STAT;
   assign sel_clr = req.addr == `OFF_IRQ_CLR;
   assign sel_mode = req.addr == `OFF_MODE;
   assign sel_chep = req.addr == `OFF_CHEP;
   assign sel_count = req.addr == `OFF_COUNT;
   assign sel_capt_a = req.addr == `OFF_CAPT_A;
   assign sel_capt_b = req.addr == `OFF_CAPT_B;

   // unmapped and write-only addresses read as zero
   assign rd_mux = sel_ctrl ? ctrl :
      sel_en ? 32'(irq_en) :
      sel_stat ? 32'(stat) :
      sel_mode ? mode_reg :
      sel_chep ? 32'(chep) :
      sel_count ? 32'(count) :
      sel_capt_a ? 32'(cap_a_value) :
      sel_capt_b ? 32'(cap_b_value) : `ZERO32;

   // ---------------------------------------------------------------
   // register fields
   // ---------------------------------------------------------------
   assign count_enable = ctrl[`CTRL_COUNT_EN];
   assign protection_level = ctrl[`CTRL_PROTECTION_LEVEL_LO +: 2];
   assign locked = protection_level[`PROTECTION_LEVEL_LOCK_BIT];
   assign chan_a_enable = chep[`CHEP_A_EN];
   assign chan_a_polarity = chep[`CHEP_A_POL];
   assign chan_a_comp_polarity = chep[`CHEP_A_NPOL];
   assign chan_b_enable = chep[`CHEP_B_EN];
   assign chan_b_polarity = chep[`CHEP_B_POL];
   assign chan_b_comp_polarity = chep[`CHEP_B_NPOL];

   assign cfg_a = {mode_reg[`MODE_A_MS +: 2], mode_reg[`MODE_A_PSC +: 2],
      chan_a_enable, chan_a_polarity, chan_a_comp_polarity};
   assign cfg_b = {mode_reg[`MODE_B_MS +: 2], mode_reg[`MODE_B_PSC +: 2],
      chan_b_enable, chan_b_polarity, chan_b_comp_polarity};

   // ---------------------------------------------------------------
   // write data
   // ---------------------------------------------------------------
   assign ctrl_wr = merge_lanes(ctrl, req.wdata, req.be) & `CTRL_MASK;
   assign en_wr = merge_lanes(32'(irq_en), req.wdata, req.be);
   assign next_irq_en = (wr_go && sel_en) ? en_wr[2:0] : irq_en;

   // mode fields only change while their channel is off
   assign mode_wr = merge_lanes(mode_reg, req.wdata, req.be) & `MODE_MASK;
   assign mode_hold = (chan_a_enable ? `MODE_A_FIELD : `ZERO32) |
      (chan_b_enable ? `MODE_B_FIELD : `ZERO32);
   assign next_mode = (wr_go && sel_mode) ?
      (mode_wr & ~mode_hold) | (mode_reg & mode_hold) : mode_reg;

   // reserved bits are forced to zero rather than trusted
   assign chep_wr = 16'(merge_lanes(32'(chep), req.wdata, req.be))
      & `CHEP_WR_MASK;
   assign pol_keep = locked ? `CHEP_POL_MASK : `CHEP_RESET;
   assign next_chep = (wr_go && sel_chep) ?
      (chep_wr & ~pol_keep) | (chep & pol_keep) : chep;

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   assign count_wr = 16'(merge_lanes(32'(count), req.wdata, req.be));
   assign wr_count = wr_go & sel_count & (|req.be[1:0]);
   assign next_count = wr_count ? count_wr :
      count_enable ? count + `COUNT_STEP : count;
   assign overflow_evt = count_enable & ~wr_count & (count == `COUNT_TOP);

   // ---------------------------------------------------------------
   // interrupt status
   // ---------------------------------------------------------------
   assign events = {overflow_evt, cap_b_pulse, cap_a_pulse};
   assign clr_bits = (wr_go && sel_clr) ? 3'(req.wdata) : `STAT_RESET;
   // an event in the clearing cycle survives the clear
   assign next_stat = (stat & ~clr_bits) | events;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         waitreq <= 1'b1;
         rdata <= `ZERO32;
      end
      else
      begin
         waitreq <= ~(req_any & waitreq);
         rdata <= rd_take ? rd_mux : `ZERO32;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         ctrl <= `CTRL_RESET;
         mode_reg <= `MODE_RESET;
         chep <= `CHEP_RESET;
         irq_en <= `STAT_RESET;
      end
      else
      begin
         if (wr_go && sel_ctrl)
            ctrl <= ctrl_wr;
         mode_reg <= next_mode;
         chep <= next_chep;
         irq_en <= next_irq_en;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         count <= `COUNT_RESET;
         stat <= `STAT_RESET;
         irq <= 1'b0;
      end
      else
      begin
         count <= next_count;
         stat <= next_stat;
         irq <= |(next_stat & next_irq_en);
      end
   end

   assign AVS_WAITREQUEST = waitreq;
   assign AVS_READDATA = rdata;
   assign IRQ = irq;
   assign CHAN_A_OUT = chan_a_output;
   assign CHAN_A_OE = chan_a_oe;
   assign CHAN_B_OUT = chan_b_output;
   assign CHAN_B_OE = chan_b_oe;

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   chan_path u_chan_a
   (
      .clk(CORE_CLK),
      .srst(SRST),
      .pin_in(CHAN_A_IN),
      .alt_in(filtered_input_b_to_a),
      .trig_in(TRIG_IN),
      .out_prep(OUT_PREP_A),
      .cfg(cfg_a),
      .count(count),
      .filt(filtered_input_a_to_a),
      .cap_pulse(cap_a_pulse),
      .cap_value(cap_a_value),
      .pin_out(chan_a_output),
      .pin_oe(chan_a_oe)
   );

   chan_path u_chan_b
   (
      .clk(CORE_CLK),
      .srst(SRST),
      .pin_in(CHAN_B_IN),
      .alt_in(filtered_input_a_to_a),
      .trig_in(TRIG_IN),
      .out_prep(OUT_PREP_B),
      .cfg(cfg_b),
      .count(count),
      .filt(filtered_input_b_to_a),
      .cap_pulse(cap_b_pulse),
      .cap_value(cap_b_value),
      .pin_out(chan_b_output),
      .pin_oe(chan_b_oe)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   a_wait_single: assert property (
      (req_any && waitreq) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("waitrequest not one cycle");
   a_pol_locked: assert property (
      (wr_go && sel_chep && locked) |=>
      (chep & `CHEP_POL_MASK) == $past(chep & `CHEP_POL_MASK))
      else $error("polarity changed while locked");
   a_chep_layout: assert property (
      (wr_go && sel_chep && !locked && req.be == `BE_WORD) |=>
      chep == ($past(req.wdata[15:0]) & `CHEP_WR_MASK))
      else $error("channel bits misplaced");
   a_enable_free: assert property (
      (wr_go && sel_chep && locked && req.be == `BE_WORD) |=>
      chan_b_enable == $past(req.wdata[`CHEP_B_EN]))
      else $error("second enable not written");
   a_count_load: assert property (
      (wr_go && sel_count && req.be == `BE_WORD) |=>
      count == $past(req.wdata[15:0]))
      else $error("counter write lost");
   a_count_half: assert property (
      (wr_go && sel_count && req.be == `BE_HALF) |=>
      count == $past(req.wdata[15:0]))
      else $error("half-word counter write lost");
   a_count_read: assert property (
      (rd_take && sel_count) |=>
      !AVS_WAITREQUEST && AVS_READDATA == 32'($past(count)))
      else $error("counter read wrong");
   a_count_step: assert property (
      (count_enable && !wr_count) |=> count == $past(count) + `COUNT_STEP)
      else $error("counter did not step");
   a_oe_mode: assert property (
      (cfg_a.mode != `MS_OUTPUT || !chan_a_enable) |=> !CHAN_A_OE)
      else $error("input channel drives pin");
   a_irq_level: assert property (IRQ == |(stat & irq_en))
      else $error("interrupt level wrong");
   a_stat_sticky: assert property (
      (cap_a_pulse || (stat[`STAT_CAP_A] && !clr_bits[`STAT_CAP_A]))
      |=> stat[`STAT_CAP_A])
      else $error("capture flag lost");

   c_capture_a: cover property (cap_a_pulse && cfg_a.psc != `PSC_DIV1);
   c_overflow: cover property (overflow_evt);
   c_locked_write: cover property (wr_go && sel_chep && locked);
   c_half_write: cover property (wr_count && req.be == `BE_HALF);
endmodule
